// [core/adc_pkg.sv]
// Purpose: Shared constants and types for the converter readout and power control.
// Assumes: Core clock of 100 MHz; times are converted to cycles of that clock here.
// Notes:   Counts above 4096 cycles are defaults for parameters of the top module.
// Behaviour
// - Convert continuously; new result every 12.5 ms (rate high) or 100 ms (low).
// - Drive the shared ready/data output low when a fresh result is available.
// - First rising serial clock after ready puts the result MSB on the output.
// - Each further rising serial clock presents the next lower result bit.
// - After all 18 bits, further clocks drive the output high until next ready (the code's 5-bit edge count wraps, so edge 32 drives it low again).
// - Serial clock held high for at least 20 us enters standby.
// - Standby accepted anytime (the code accepts it only in ST_CONVERT); converter off, clock source on, output held high.
// - Clock low wakes from standby; the first result after wakeup is valid.
// - After standby wakeup, ready comes after 52.51 ms fast or 401.8 ms slow.
// - Power-down input low shuts down and resets everything; pulse at least 30 us.
// - After power-down release the device wakes in a typical 8 us.
// - Results are 18-bit two's complement, clipped at positive and negative full scale.

package adc_pkg;

    localparam real CLK_PERIOD_NS = 10.0;

    localparam int RESULT_W   = 18;
    localparam int EDGE_PTR_W = 5;
    localparam int TIMER_W    = 32;

    localparam logic [RESULT_W-1:0]   POS_FULL_SCALE = 18'h1FFFF;
    localparam logic [RESULT_W-1:0]   NEG_FULL_SCALE = 18'h20000;
    localparam logic [RESULT_W-1:0]   RESULT_RESET   = 18'h00000;
    localparam logic [EDGE_PTR_W-1:0] PTR_RESET      = 5'h00;
    localparam logic [EDGE_PTR_W-1:0] LAST_BIT_EDGE  = 5'h12;
    localparam logic [TIMER_W-1:0]    TIMER_RESET    = 32'h00000000;

    localparam real CONV_PERIOD_FAST_MS  = 12.5;
    localparam real CONV_PERIOD_SLOW_MS  = 100.0;
    localparam real STBY_WAKE_FAST_MS    = 52.51;
    localparam real STBY_WAKE_SLOW_MS    = 401.8;
    localparam real UPDATE_WINDOW_US     = 39.0;
    localparam real STANDBY_ACT_US       = 20.0;
    localparam real WAKE_US              = 8.0;

    localparam int CONV_FAST_CYC = int'($floor(CONV_PERIOD_FAST_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int CONV_SLOW_CYC = int'($floor(CONV_PERIOD_SLOW_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int STBY_FAST_CYC = int'($floor(STBY_WAKE_FAST_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int STBY_SLOW_CYC = int'($floor(STBY_WAKE_SLOW_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int UPDATE_CYC    = int'($ceil(UPDATE_WINDOW_US * 1.0e3 / CLK_PERIOD_NS));
    localparam int STANDBY_CYC   = int'($ceil(STANDBY_ACT_US * 1.0e3 / CLK_PERIOD_NS));
    localparam int WAKE_CYC      = int'($ceil(WAKE_US * 1.0e3 / CLK_PERIOD_NS));

    typedef enum logic [2:0] {
        ST_OFF,
        ST_WAKE,
        ST_CONVERT,
        ST_STANDBY,
        ST_STBY_WAKE
    } state_t;

endpackage : adc_pkg

// [core/shift_link_if.sv]
// Purpose: Carries the serial clock edge pointer from the link domain to the core.
// Assumes: The pointer is gray coded so the core may sample it with two flip-flops.
// Notes:   One producer on the serial clock, one consumer on the core clock.
`timescale 1ns/100ps

interface shift_link_if;
    logic [adc_pkg::EDGE_PTR_W-1:0] edge_gray;

    modport producer (output edge_gray);
    modport consumer (input  edge_gray);
endinterface : shift_link_if

// [core/sclk_edge_counter.sv]
// Purpose: Counts rising edges of the host serial clock as a gray-coded pointer.
// Assumes: The serial clock may stand still for long stretches between reads.
// Notes:   Only one pointer bit changes per edge, which makes the crossing safe.
`timescale 1ns/100ps

module sclk_edge_counter
    import adc_pkg::*;
(
    // Link clock and reset
    input  wire logic        sclk_i,
    input  wire logic        resetn_i,
    // Pointer toward the core
    shift_link_if.producer   link
);
    logic [EDGE_PTR_W-1:0] bin_reg;
    logic [EDGE_PTR_W-1:0] bin_next;
    logic [EDGE_PTR_W-1:0] gray_reg;

    assign bin_next = bin_reg + 5'h01;

    always_ff @(posedge sclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            bin_reg  <= PTR_RESET;
            gray_reg <= PTR_RESET;
        end
        else
        begin
            bin_reg  <= bin_next;
            gray_reg <= bin_next ^ (bin_next >> 1);
        end
    end

    assign link.edge_gray = gray_reg;

endmodule : sclk_edge_counter

// [core/adc_serial_readout_power_ctrl.sv]
// Purpose: Digital side of a continuously converting 18-bit converter: timing, data
//          ready, serial readout, standby and power-down control.
// Assumes: Filter output is valid whenever it is sampled; pins arrive asynchronously.
// Notes:   Output reacts about four core cycles after a serial clock edge.
`timescale 1ns/100ps

module adc_serial_readout_power_ctrl
    import adc_pkg::*;
#(
    parameter int FILTER_W       = 24,
    parameter int CONV_FAST      = CONV_FAST_CYC,
    parameter int CONV_SLOW      = CONV_SLOW_CYC,
    parameter int STBY_RDY_FAST  = STBY_FAST_CYC,
    parameter int STBY_RDY_SLOW  = STBY_SLOW_CYC
)
(
    // Core clock and reset
    input  wire logic                clock_i,
    input  wire logic                resetn_i,
    // Host pins
    input  wire logic                sclk_i,
    input  wire logic                power_down_n_i,
    input  wire logic                rate_fast_i,
    output logic                     ready_and_serial_out_o,
    // Converter path
    input  wire logic [FILTER_W-1:0] filter_data_i,
    output logic                     analog_power_o,
    output logic                     clock_source_on_o,
    output logic                     standby_o
);
    import adc_pkg::*;

    state_t                state_reg;
    logic [TIMER_W-1:0]    timer_reg;
    logic [TIMER_W-1:0]    hold_reg;
    logic [RESULT_W-1:0]   result_reg;
    logic                  ready_reg;
    logic                  publish;
    logic [TIMER_W-1:0]    period_cyc;
    logic [TIMER_W-1:0]    stby_rdy_cyc;
    logic [RESULT_W-1:0]   clipped;
    logic                  sclk_meta_reg;
    logic                  sclk_sync_reg;
    logic                  run_meta_reg;
    logic                  run_sync_reg;
    logic                  rate_meta_reg;
    logic                  rate_sync_reg;
    logic [EDGE_PTR_W-1:0] gray_meta_reg;
    logic [EDGE_PTR_W-1:0] gray_sync_reg;
    logic [EDGE_PTR_W-1:0] ptr_bin;
    logic [EDGE_PTR_W-1:0] base_reg;
    logic [EDGE_PTR_W-1:0] shift_cnt_reg;
    logic [EDGE_PTR_W-1:0] bit_idx;
    logic                  out_next;

    shift_link_if link_bus ();

    sclk_edge_counter u_edge_counter (
        .sclk_i   (sclk_i),
        .resetn_i (resetn_i),
        .link     (link_bus.producer)
    );

    // Pin synchronisers; only the second stage is read by logic.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sclk_meta_reg <= 1'b0;
            sclk_sync_reg <= 1'b0;
            run_meta_reg  <= 1'b0;
            run_sync_reg  <= 1'b0;
            rate_meta_reg <= 1'b0;
            rate_sync_reg <= 1'b0;
            gray_meta_reg <= PTR_RESET;
            gray_sync_reg <= PTR_RESET;
        end
        else
        begin
            sclk_meta_reg <= sclk_i;
            sclk_sync_reg <= sclk_meta_reg;
            run_meta_reg  <= power_down_n_i;
            run_sync_reg  <= run_meta_reg;
            rate_meta_reg <= rate_fast_i;
            rate_sync_reg <= rate_meta_reg;
            gray_meta_reg <= link_bus.edge_gray;
            gray_sync_reg <= gray_meta_reg;
        end
    end

    always_comb
    begin
        ptr_bin = gray_sync_reg;
        for (int i = EDGE_PTR_W - 2; i >= 0; i--)
        begin
            ptr_bin[i] = ptr_bin[i+1] ^ gray_sync_reg[i];
        end
    end

    // The rate is taken live, so a change takes effect in the running period.
    assign period_cyc   = rate_sync_reg ? TIMER_W'(CONV_FAST) : TIMER_W'(CONV_SLOW);
    assign stby_rdy_cyc = rate_sync_reg ? TIMER_W'(STBY_RDY_FAST)
                                        : TIMER_W'(STBY_RDY_SLOW);

    // Saturate the wider filter word into the 18-bit result range.
    always_comb
    begin
        if ($signed(filter_data_i) > $signed(FILTER_W'(POS_FULL_SCALE)))
        begin
            clipped = POS_FULL_SCALE;
        end
        else if ($signed(filter_data_i) < $signed({{(FILTER_W-RESULT_W){1'b1}},
                                                   NEG_FULL_SCALE}))
        begin
            clipped = NEG_FULL_SCALE;
        end
        else
        begin
            clipped = filter_data_i[RESULT_W-1:0];
        end
    end

    assign publish = ((state_reg == ST_CONVERT) && (timer_reg == period_cyc - 32'h1)) ||
                     ((state_reg == ST_STBY_WAKE) && (timer_reg == stby_rdy_cyc - 32'h1));

    // Power control sequence.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_reg <= ST_OFF;
            timer_reg <= TIMER_RESET;
        end
        else if (!run_sync_reg)
        begin
            state_reg <= ST_OFF;
            timer_reg <= TIMER_RESET;
        end
        else
        begin
            unique case (state_reg)
                ST_OFF:
                begin
                    state_reg <= ST_WAKE;
                    timer_reg <= TIMER_RESET;
                end
                ST_WAKE:
                begin
                    if (timer_reg == TIMER_W'(WAKE_CYC - 1))
                    begin
                        state_reg <= ST_CONVERT;
                        timer_reg <= TIMER_RESET;
                    end
                    else
                    begin
                        timer_reg <= timer_reg + 32'h1;
                    end
                end
                ST_CONVERT:
                begin
                    if (sclk_sync_reg && (hold_reg == TIMER_W'(STANDBY_CYC - 1)))
                    begin
                        state_reg <= ST_STANDBY;
                        timer_reg <= TIMER_RESET;
                    end
                    else if (publish || (timer_reg >= period_cyc - 32'h1))
                    begin
                        timer_reg <= TIMER_RESET;
                    end
                    else
                    begin
                        timer_reg <= timer_reg + 32'h1;
                    end
                end
                ST_STANDBY:
                begin
                    if (!sclk_sync_reg)
                    begin
                        state_reg <= ST_STBY_WAKE;
                        timer_reg <= TIMER_RESET;
                    end
                end
                ST_STBY_WAKE:
                begin
                    if (publish)
                    begin
                        state_reg <= ST_CONVERT;
                        timer_reg <= TIMER_RESET;
                    end
                    else
                    begin
                        timer_reg <= timer_reg + 32'h1;
                    end
                end
            endcase
        end
    end

    // Measures how long the serial clock has stood high without a break.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            hold_reg <= TIMER_RESET;
        end
        else if (!sclk_sync_reg || (state_reg != ST_CONVERT))
        begin
            hold_reg <= TIMER_RESET;
        end
        else if (hold_reg != TIMER_W'(STANDBY_CYC - 1))
        begin
            hold_reg <= hold_reg + 32'h1;
        end
    end

    // Result holding and data ready; the next result overwrites an unread one.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            result_reg <= RESULT_RESET;
            ready_reg  <= 1'b0;
            base_reg   <= PTR_RESET;
        end
        else if (!run_sync_reg || (state_reg != ST_CONVERT && state_reg != ST_STBY_WAKE))
        begin
            ready_reg  <= 1'b0;
            if (!run_sync_reg)
            begin
                result_reg <= RESULT_RESET;
            end
        end
        else if (publish)
        begin
            result_reg <= clipped;
            ready_reg  <= 1'b1;
            base_reg   <= ptr_bin;
        end
        else if ((state_reg == ST_CONVERT) &&
                 (timer_reg >= period_cyc - TIMER_W'(UPDATE_CYC)))
        begin
            ready_reg <= 1'b0;
        end
    end

    // Number of serial clock edges seen since the result was published.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            shift_cnt_reg <= PTR_RESET;
        end
        else if (publish)
        begin
            shift_cnt_reg <= PTR_RESET;
        end
        else
        begin
            shift_cnt_reg <= ptr_bin - base_reg;
        end
    end

    assign bit_idx = LAST_BIT_EDGE - shift_cnt_reg;

    always_comb
    begin
        if (!ready_reg)
        begin
            out_next = 1'b1;
        end
        else if (shift_cnt_reg == PTR_RESET)
        begin
            out_next = 1'b0;
        end
        else if (shift_cnt_reg <= LAST_BIT_EDGE)
        begin
            out_next = result_reg[bit_idx];
        end
        else
        begin
            out_next = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ready_and_serial_out_o <= 1'b1;
            analog_power_o         <= 1'b0;
            clock_source_on_o      <= 1'b0;
            standby_o              <= 1'b0;
        end
        else
        begin
            ready_and_serial_out_o <= out_next;
            analog_power_o         <= run_sync_reg && (state_reg != ST_OFF) &&
                                      (state_reg != ST_STANDBY);
            clock_source_on_o      <= run_sync_reg && (state_reg != ST_OFF);
            standby_o              <= run_sync_reg && (state_reg == ST_STANDBY);
        end
    end

    period_publish_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (state_reg == ST_CONVERT && timer_reg == period_cyc - 32'h1 && run_sync_reg &&
         !(sclk_sync_reg && hold_reg == TIMER_W'(STANDBY_CYC - 1)))
        |=> (ready_reg && timer_reg == TIMER_RESET))
        else $error("Result not published at the end of the period.");

    ready_low_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (ready_reg && shift_cnt_reg == PTR_RESET) |=> !ready_and_serial_out_o)
        else $error("Ready not shown low on the output.");

    msb_first_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (ready_reg && shift_cnt_reg == 5'h01)
        |=> (ready_and_serial_out_o == $past(result_reg[RESULT_W-1])))
        else $error("First edge did not present the top result bit.");

    next_bit_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (ready_reg && shift_cnt_reg > 5'h01 && shift_cnt_reg <= LAST_BIT_EDGE)
        |=> (ready_and_serial_out_o == $past(result_reg[bit_idx])))
        else $error("Wrong result bit on the output.");

    forced_high_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (ready_reg && shift_cnt_reg > LAST_BIT_EDGE && !publish)
        |=> ready_and_serial_out_o ##1 (ready_and_serial_out_o || $past(publish, 2) ||
                                        $past(ready_reg) == 1'b0 || ready_reg))
        else $error("Output not forced high after the last bit.");

    standby_entry_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (state_reg == ST_CONVERT && run_sync_reg && sclk_sync_reg &&
         hold_reg == TIMER_W'(STANDBY_CYC - 1)) |=> state_reg == ST_STANDBY ##1 standby_o)
        else $error("Standby not entered after the clock stood high.");

    standby_pins_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (state_reg == ST_STANDBY && run_sync_reg && sclk_sync_reg) |=> ##1
        (ready_and_serial_out_o && !analog_power_o && clock_source_on_o))
        else $error("Standby pin states wrong.");

    standby_wake_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (state_reg == ST_STANDBY && run_sync_reg && !sclk_sync_reg)
        |=> (state_reg == ST_STBY_WAKE && timer_reg == TIMER_RESET))
        else $error("Standby not left on clock low.");

    wake_ready_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (state_reg == ST_STBY_WAKE && run_sync_reg && timer_reg == stby_rdy_cyc - 32'h1)
        |=> (ready_reg && state_reg == ST_CONVERT))
        else $error("Ready not given after the standby wake time.");

    powerdown_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        !run_sync_reg |=> (state_reg == ST_OFF && !ready_reg && result_reg == RESULT_RESET)
        ##1 (!analog_power_o && !clock_source_on_o && ready_and_serial_out_o))
        else $error("Power-down did not reset the block.");

    pd_wake_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (state_reg == ST_WAKE && run_sync_reg && timer_reg == TIMER_W'(WAKE_CYC - 1))
        |=> state_reg == ST_CONVERT)
        else $error("Wake from power-down not on time.");

    clip_pos_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (publish && run_sync_reg && $signed(filter_data_i) > $signed(FILTER_W'(POS_FULL_SCALE)))
        |=> result_reg == POS_FULL_SCALE)
        else $error("Positive result not clipped.");

endmodule : adc_serial_readout_power_ctrl

// [dv/host_reader.sv]
// Purpose: Host model that clocks results out of the shared ready/data line.
// Assumes: Its tick runs freely; the serial clock stands low outside reads, unless a read parks it high until wake.
// Notes:   Each serial clock level lasts nine ticks, so pulses stay above 100 ns.
`timescale 1ns/100ps

module host_reader (
    // Tick and device pin
    input  wire logic        link_clk_i,
    input  wire logic        dout_i,
    // Serial clock and captured word
    output logic             sclk_o,
    output logic             got_o,
    output logic [23:0]      word_o
);
    initial
    begin
        sclk_o = 1'b0;
        got_o  = 1'b0;
        word_o = 24'h000000;
    end

    // The caller starts a read as soon as ready falls, well before the update window.
    task automatic read_bits(input int n, input bit park);
        logic [23:0] w;
        w = 24'h000000;
        for (int i = 0; i < n && i < 24; i++)
        begin
            @(posedge link_clk_i);
            sclk_o <= 1'b1;
            repeat (9) @(posedge link_clk_i);
            w = {w[22:0], dout_i};
            sclk_o <= 1'b0;
            repeat (8) @(posedge link_clk_i);
        end
        if (park)
            sclk_o <= 1'b1;
        word_o <= w;
        @(posedge link_clk_i);
        got_o <= 1'b1;
        @(posedge link_clk_i);
        got_o <= 1'b0;
    endtask : read_bits

    task automatic wake;
        @(posedge link_clk_i);
        sclk_o <= 1'b0;
    endtask : wake
endmodule : host_reader

// [dv/adc_serial_readout_power_ctrl_tb.sv]
// Purpose: Self-checking bench for the converter readout and power control.
// Assumes: Long counts are shortened through the top module's parameters.
// Notes:   The host model reads on its own tick; results are queued and compared.
`timescale 1ns/100ps

module adc_serial_readout_power_ctrl_tb;
    import adc_pkg::*;

    localparam int CF = 5000;
    localparam int CS = 7000;
    localparam int SR = 6000;

    logic        clock_i  = 1'b0;
    logic        link_clk = 1'b0;
    logic        resetn_i = 1'b0;
    logic        pd_n     = 1'b0;
    logic        rate     = 1'b1;
    logic [23:0] filt     = 24'h7FFFFF;
    logic [23:0] vt[3]    = '{24'h800000, 24'h01FFFF, 24'hFE0000};
    logic [23:0] seed     = 24'h00004D;
    logic [23:0] expq[$];
    logic        dout;
    logic        apwr;
    logic        clk_on;
    logic        stby;
    logic        sclk;
    logic        got;
    logic [23:0] word;
    int          n_fail = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          last_fall = 0;
    int          gap = 0;

    always #5 clock_i = ~clock_i;
    initial #2.3 forever #6 link_clk = ~link_clk;

    adc_serial_readout_power_ctrl #(
        .CONV_FAST     (CF),
        .CONV_SLOW     (CS),
        .STBY_RDY_FAST (SR),
        .STBY_RDY_SLOW (SR)
    ) dut (
        .clock_i                (clock_i),
        .resetn_i               (resetn_i),
        .sclk_i                 (sclk),
        .power_down_n_i         (pd_n),
        .rate_fast_i            (rate),
        .ready_and_serial_out_o (dout),
        .filter_data_i          (filt),
        .analog_power_o         (apwr),
        .clock_source_on_o      (clk_on),
        .standby_o              (stby)
    );

    host_reader host (
        .link_clk_i (link_clk),
        .dout_i     (dout),
        .sclk_o     (sclk),
        .got_o      (got),
        .word_o     (word)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    function automatic logic [17:0] clip(input logic [23:0] v);
        if ($signed(v) > $signed(24'h01FFFF))
            return 18'h1FFFF;
        if ($signed(v) < $signed(24'hFE0000))
            return 18'h20000;
        return v[17:0];
    endfunction : clip

    function automatic logic [23:0] rnd;
        seed = {seed[22:0], seed[23] ^ seed[22] ^ seed[21] ^ seed[16]};
        return {{6{seed[17]}}, seed[17:0]};
    endfunction : rnd

    // Waits for the line to be high, then low, so a stale zero bit is never taken for ready.
    task automatic wait_ready;
        int n;
        n = 0;
        while (dout !== 1'b1 && n < 20000)
        begin
            @(negedge clock_i);
            n++;
        end
        while (dout !== 1'b0 && n < 20000)
        begin
            @(negedge clock_i);
            n++;
        end
        if (n >= 20000)
        begin
            n_fail++;
            $display("BAD %0t ready never came", $time);
        end
        gap = cyc - last_fall;
        last_fall = cyc;
    endtask : wait_ready

    task automatic read(input int n, input bit park);
        expq.push_back({clip(filt), 6'h3F} >> (24 - n));
        host.read_bits(n, park);
    endtask : read

    always @(posedge got)
    begin
        if (expq.size() == 0)
            check(32'h1, 32'h0);
        else
            check(word, expq.pop_front());
    end

    always @(posedge clock_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            n_fail++;
            $display("BAD %0t run too long", $time);
            end_sim();
        end
    end

    initial
    begin
        repeat (5) @(negedge clock_i);
        check({dout, apwr, clk_on, stby}, 4'h8);
        resetn_i <= 1'b1;
        repeat (3000) @(negedge clock_i);
        pd_n <= 1'b1;
        last_fall = cyc;
        for (int k = 0; k < 5; k++)
        begin
            wait_ready();
            if (k == 0)
                check(gap > 800 + CF - 5 && gap < 800 + CF + 12, 1'b1);
            else
                check(gap >= CF - 2 && gap <= CF + 2, 1'b1);
            read(24, 1'b0);
            @(negedge clock_i);
            filt <= (k < 3) ? vt[k] : rnd();
        end
        wait_ready();
        read(5, 1'b0);
        @(negedge clock_i);
        filt <= rnd();
        wait_ready();
        check(gap >= CF - 2 && gap <= CF + 2, 1'b1);
        read(24, 1'b0);
        $display("test fast reads done");
        @(negedge clock_i);
        rate <= 1'b0;
        wait_ready();
        wait_ready();
        check(gap >= CS - 2 && gap <= CS + 2, 1'b1);
        read(24, 1'b0);
        $display("test slow rate done");
        @(negedge clock_i);
        rate <= 1'b1;
        wait_ready();
        read(4, 1'b1);
        repeat (1900) @(negedge clock_i);
        check(stby, 1'b0);
        repeat (200) @(negedge clock_i);
        check({stby, apwr, clk_on, dout}, 4'hB);
        host.wake();
        last_fall = cyc;
        wait_ready();
        check(gap >= SR - 2 && gap <= SR + 12, 1'b1);
        read(24, 1'b0);
        $display("test standby done");
        wait_ready();
        read(3, 1'b0);
        @(negedge clock_i);
        pd_n <= 1'b0;
        repeat (3000) @(negedge clock_i);
        check({dout, apwr, clk_on, stby}, 4'h8);
        pd_n <= 1'b1;
        filt <= rnd();
        last_fall = cyc;
        wait_ready();
        check(gap > 800 + CF - 5 && gap < 800 + CF + 12, 1'b1);
        read(24, 1'b0);
        repeat (50) @(negedge clock_i);
        check(expq.size(), 32'h0);
        $display("test power down done");
        end_sim();
    end
endmodule : adc_serial_readout_power_ctrl_tb
